// ===== pkg/sphp_defines.svh
// constants for the strobed parallel handshake port
`ifndef SPHP_DEFINES_SVH
`define SPHP_DEFINES_SVH
`define SPHP_DATA_W 8
`define SPHP_FIFO_DEPTH 8
`define SPHP_MODE_W 2
`define SPHP_MODE_OFF 2'h0
`define SPHP_MODE_ONE 2'h1
`define SPHP_MODE_TWO 2'h2
`define SPHP_SRC_COUNT 5
`define SPHP_SRC_DIO 3
`endif

// ===== pkg/sphp_pkg.sv
// types for the strobed parallel handshake port
package sphp_pkg;
	typedef struct packed {
		logic enable;
		logic [1:0] mode;
		logic out_dir;
		logic ie_in;
		logic ie_out;
	} sphp_cfg_t;
	typedef enum logic [2:0] {
		SPHP_OUT_IDLE = 3'h1,
		SPHP_OUT_FULL = 3'h2,
		SPHP_OUT_WAIT = 3'h4
	} sphp_out_state_t;
endpackage

// ===== logic/sphp_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module sphp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// fill side
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// drain side
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	wire [AW-1:0] wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
	wire [AW-1:0] rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
	assign in_ready_o = (cnt_reg != (AW + 1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o = mem_reg[rd_reg];
	always_ff @(posedge clk_sys_i) begin
		if (push)
			mem_reg[wr_reg] <= in_data_i;
	end
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= wr_next;
			if (pop)
				rd_reg <= rd_next;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

// ===== logic/sphp_port.sv
// strobed parallel handshake port with mode 1 and mode 2 transfers
`timescale 1ns/100ps
`include "sphp_defines.svh"
module sphp_port
	import sphp_pkg::*;
#(
	parameter int DATA_W = `SPHP_DATA_W,
	parameter int FIFO_DEPTH = `SPHP_FIFO_DEPTH,
	parameter int SRC_COUNT = `SPHP_SRC_COUNT
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// static configuration from the host interface
	input wire sphp_cfg_t cfg_i,
	// host byte access, strobes active low, same clock
	input wire logic host_read_n_i,
	input wire logic host_write_n_i,
	input wire logic [DATA_W-1:0] host_wdata_i,
	output logic [DATA_W-1:0] host_rdata_o,
	output logic host_wready_o,
	// external device pins
	input wire logic input_strobe_n_i,
	input wire logic ack_n_i,
	input wire logic [DATA_W-1:0] port_data_i,
	output logic [DATA_W-1:0] port_data_o,
	output logic port_data_oe_o,
	output logic input_buffer_full_o,
	output logic output_buffer_full_n_o,
	output logic service_request_o,
	// board interrupt sources
	input wire logic [SRC_COUNT-1:0] src_event_i,
	input wire logic [SRC_COUNT-1:0] src_enable_i,
	input wire logic [SRC_COUNT-1:0] src_clear_i,
	output logic [SRC_COUNT-1:0] src_pending_o,
	output logic board_irq_o
);
	// pin synchronisers
	logic [1:0] stb_sync_reg;
	logic [1:0] ack_sync_reg;
	logic [DATA_W-1:0] din_s1_reg;
	logic [DATA_W-1:0] din_s2_reg;
	logic stb_prev_reg;
	logic ack_prev_reg;
	// host strobe edge detection
	logic rd_prev_reg;
	logic wr_prev_reg;
	// input side
	logic [DATA_W-1:0] latch_reg;
	logic ibf_reg;
	// output side
	sphp_out_state_t out_state_reg;
	sphp_out_state_t out_state_next;
	logic [DATA_W-1:0] out_byte_reg;
	logic obf_n_reg;
	logic oe_reg;
	logic service_request_in_reg;
	logic service_request_out_reg;
	logic srq_reg;
	logic [SRC_COUNT-1:0] pend_reg;
	logic irq_reg;
	logic wready_reg;
	// fifo wires
	logic fifo_in_ready;
	logic [DATA_W-1:0] fifo_out_data;
	logic fifo_out_valid;

	wire mode_one = cfg_i.enable && (cfg_i.mode == `SPHP_MODE_ONE);
	wire mode_two = cfg_i.enable && (cfg_i.mode == `SPHP_MODE_TWO);
	wire in_active = (mode_one && !cfg_i.out_dir) || mode_two;
	wire out_active = (mode_one && cfg_i.out_dir) || mode_two;
	wire stb_low = !stb_sync_reg[1];
	wire stb_fall = stb_prev_reg && stb_low;
	// one falling-edge test shared by the acknowledge and host strobes
	function automatic logic fell_f(input logic prev, input logic now);
		return prev && !now;
	endfunction
	wire ack_fall = fell_f(ack_prev_reg, ack_sync_reg[1]);
	wire rd_fall = fell_f(rd_prev_reg, host_read_n_i);
	wire wr_fall = fell_f(wr_prev_reg, host_write_n_i);
	// a full latch refuses a second strobe until the host reads it
	wire capture = in_active && stb_fall && !ibf_reg;
	wire host_rd_latch = rd_fall && in_active;
	wire host_push = wr_fall && out_active;
	wire out_load = (out_state_reg == SPHP_OUT_IDLE) && fifo_out_valid;
	wire out_take = (out_state_reg == SPHP_OUT_FULL) && ack_fall;
	// in mode 2 the pins are driven only while acknowledge is low
	wire oe_next = (mode_one && cfg_i.out_dir) ? 1'b1 :
		(mode_two && !ack_sync_reg[1]);
	wire service_request_in_next = cfg_i.ie_in && in_active && ibf_reg && stb_sync_reg[1];
	wire service_request_out_next = cfg_i.ie_out && out_active
		&& (out_state_reg == SPHP_OUT_IDLE) && !fifo_out_valid;
	wire dio_event = (service_request_in_reg || service_request_out_reg) && !srq_reg;

	// output byte sequencing, one byte per acknowledge
	always_comb begin
		out_state_next = out_state_reg;
		case (out_state_reg)
			SPHP_OUT_IDLE: begin
				if (out_active && fifo_out_valid)
					out_state_next = SPHP_OUT_FULL;
			end
			SPHP_OUT_FULL: begin
				if (ack_fall)
					out_state_next = SPHP_OUT_WAIT;
			end
			SPHP_OUT_WAIT: begin
				if (ack_sync_reg[1])
					out_state_next = SPHP_OUT_IDLE;
			end
			default: out_state_next = SPHP_OUT_IDLE;
		endcase
	end

	// host writes queue here so bursts do not wait on the external device
	sphp_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_out_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.in_data_i(host_wdata_i),
		.in_valid_i(host_push),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(out_load && out_active)
	);

	// two flip-flops on every pin before any logic looks at it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			stb_sync_reg <= 2'h3;
			ack_sync_reg <= 2'h3;
		end else begin
			stb_sync_reg <= {stb_sync_reg[0], input_strobe_n_i};
			ack_sync_reg <= {ack_sync_reg[0], ack_n_i};
		end
	end

	// data is synced bit by bit: the device must hold it around the strobe
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			din_s1_reg <= '0;
			din_s2_reg <= '0;
		end else begin
			din_s1_reg <= port_data_i;
			din_s2_reg <= din_s1_reg;
		end
	end

	// history resets to the idle high level so no false edge follows reset
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			stb_prev_reg <= 1'b1;
			ack_prev_reg <= 1'b1;
			rd_prev_reg <= 1'b1;
			wr_prev_reg <= 1'b1;
		end else begin
			stb_prev_reg <= stb_sync_reg[1];
			ack_prev_reg <= ack_sync_reg[1];
			rd_prev_reg <= host_read_n_i;
			wr_prev_reg <= host_write_n_i;
		end
	end

	// input latch
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			latch_reg <= '0;
		else if (capture)
			latch_reg <= din_s2_reg;
	end

	// buffer full flag, dropped when the input side is switched off
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			ibf_reg <= 1'b0;
		else if (capture)
			ibf_reg <= 1'b1;
		else if (host_rd_latch || !in_active)
			ibf_reg <= 1'b0;
	end

	// output handshake state
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			out_state_reg <= SPHP_OUT_IDLE;
		else
			out_state_reg <= out_active ? out_state_next : SPHP_OUT_IDLE;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			out_byte_reg <= '0;
		else if (out_load && out_active)
			out_byte_reg <= fifo_out_data;
	end

	// load and take sit in different states, so they never meet
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			obf_n_reg <= 1'b1;
		else if (out_load && out_active)
			obf_n_reg <= 1'b0;
		else if (out_take || !out_active)
			obf_n_reg <= 1'b1;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			oe_reg <= 1'b0;
		else
			oe_reg <= oe_next;
	end

	// service request
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			service_request_in_reg <= 1'b0;
			service_request_out_reg <= 1'b0;
			srq_reg <= 1'b0;
		end else begin
			service_request_in_reg <= service_request_in_next && !host_rd_latch;
			service_request_out_reg <= service_request_out_next && !host_push;
			srq_reg <= service_request_in_reg || service_request_out_reg;
		end
	end

	// board sources: the port's own request joins at its fixed index
	wire [SRC_COUNT-1:0] src_set;
	generate
		for (genvar g = 0; g < SRC_COUNT; g++) begin : g_src
			assign src_set[g] = src_event_i[g]
				|| (g == `SPHP_SRC_DIO && dio_event);
		end
	endgenerate
	// a new event in the clear cycle survives the clear
	wire [SRC_COUNT-1:0] pend_next = src_set | (pend_reg & ~src_clear_i);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			pend_reg <= '0;
		else
			pend_reg <= pend_next;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(pend_reg & src_enable_i);
	end

	// read data holds until the next read of the latch
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			host_rdata_o <= '0;
		else if (host_rd_latch)
			host_rdata_o <= latch_reg;
	end

	// ready lags the fifo by a cycle, the host must wait on it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			wready_reg <= 1'b0;
		else
			wready_reg <= fifo_in_ready && out_active;
	end

	assign input_buffer_full_o = ibf_reg;
	assign output_buffer_full_n_o = obf_n_reg;
	assign port_data_o = out_byte_reg;
	assign port_data_oe_o = oe_reg;
	assign service_request_o = srq_reg;
	assign src_pending_o = pend_reg;
	assign board_irq_o = irq_reg;
	assign host_wready_o = wready_reg;
endmodule

// ===== tb/sphp_dev_model.sv
// external device model: strobes bytes in, acknowledges bytes out
`timescale 1ns/100ps
module sphp_dev_model (
	// clock
	input wire logic clk_sys_i,
	// from the port
	input wire logic output_buffer_full_n_i,
	input wire logic [7:0] port_data_i,
	// to the port
	output logic input_strobe_n_o,
	output logic ack_n_o,
	output logic [7:0] data_o
);
	logic [7:0] rx_q[$];
	int ack_wait = 1;
	initial begin
		input_strobe_n_o = 1'b1;
		ack_n_o = 1'b1;
		data_o = 8'h00;
	end
	// strobe low long enough for the 2-ff synchroniser
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys_i);
		#1 data_o = b;
		input_strobe_n_o = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1 input_strobe_n_o = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1 data_o = ~b;
	endtask
	// long ack_wait stalls the drain so the fifo fills
	always begin
		@(posedge clk_sys_i);
		if (output_buffer_full_n_i === 1'b0) begin
			repeat (ack_wait) @(posedge clk_sys_i);
			#1 ack_n_o = 1'b0;
			repeat (5) @(posedge clk_sys_i);
			rx_q.push_back(port_data_i);
			#1 ack_n_o = 1'b1;
			repeat (5) @(posedge clk_sys_i);
		end
	end
endmodule

// ===== tb/sphp_port_monitor.sv
// concurrent checks on the port pins and host strobes
`timescale 1ns/100ps
`include "sphp_defines.svh"
module sphp_port_monitor
	import sphp_pkg::*;
#(
	parameter int SRC_COUNT = 5
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// host side
	input wire sphp_cfg_t cfg_i,
	input wire logic host_read_n_i,
	input wire logic host_write_n_i,
	input wire logic host_wready_o,
	// pins
	input wire logic input_strobe_n_i,
	input wire logic ack_n_i,
	input wire logic port_data_oe_o,
	input wire logic input_buffer_full_o,
	input wire logic output_buffer_full_n_o,
	input wire logic service_request_o,
	// board sources
	input wire logic [SRC_COUNT-1:0] src_enable_i,
	input wire logic [SRC_COUNT-1:0] src_pending_o,
	input wire logic board_irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire m1 = cfg_i.mode == `SPHP_MODE_ONE;
	wire in_act = cfg_i.enable && (cfg_i.mode == `SPHP_MODE_TWO || m1 && !cfg_i.out_dir);
	AST_IBF_RISE: assert property ($fell(input_strobe_n_i) && in_act &&
		!input_buffer_full_o |-> ##[3:5] input_buffer_full_o) else $error("no ibf");
	AST_IBF_HOLD: assert property (input_buffer_full_o && host_read_n_i &&
		$stable(cfg_i) |=> input_buffer_full_o) else $error("ibf dropped");
	AST_IBF_CLR: assert property ($fell(host_read_n_i) && input_buffer_full_o
		|-> ##[1:2] !input_buffer_full_o) else $error("ibf kept");
	AST_WR_OBF: assert property ($fell(host_write_n_i) && host_wready_o && ack_n_i
		&& output_buffer_full_n_o |-> ##[1:8] !output_buffer_full_n_o) else $error("no obf");
	AST_OBF_ACK: assert property ($fell(ack_n_i) && !output_buffer_full_n_o
		|-> ##[3:5] output_buffer_full_n_o) else $error("obf kept");
	AST_SRQ_EN: assert property (service_request_o |-> $past(cfg_i.ie_in) ||
		$past(cfg_i.ie_out) || $past(cfg_i.ie_in, 2) || $past(cfg_i.ie_out, 2))
		else $error("srq not enabled");
	AST_SRC_PEND: assert property ($rose(service_request_o) |=>
		src_pending_o[`SPHP_SRC_DIO]) else $error("no pending");
	AST_IRQ: assert property (|(src_pending_o & src_enable_i) |-> ##[0:1] board_irq_o)
		else $error("no irq");
	AST_OE_TWO: assert property ((cfg_i.mode == `SPHP_MODE_TWO && ack_n_i) [*5]
		|-> !port_data_oe_o) else $error("oe without ack");
	cover property ($rose(input_buffer_full_o));
	cover property ($fell(output_buffer_full_n_o));
	cover property ($rose(board_irq_o));
endmodule
bind sphp_port sphp_port_monitor #(.SRC_COUNT(SRC_COUNT)) mon_u (.clk_sys_i, .rst_i,
	.cfg_i, .host_read_n_i, .host_write_n_i, .host_wready_o, .input_strobe_n_i,
	.ack_n_i, .port_data_oe_o, .input_buffer_full_o, .output_buffer_full_n_o,
	.service_request_o, .src_enable_i, .src_pending_o, .board_irq_o);

// ===== tb/strobed_parallel_handshake_port_tb_top.sv
// testbench top for the strobed parallel handshake port
`timescale 1ns/100ps
module strobed_parallel_handshake_port_tb_top;
	import sphp_pkg::*;
	logic clk = 0, rst = 1, rd_n = 1, wr_n = 1, oe, input_buffer_full, obf_n, srq, wrdy, irq;
	logic stb_n, ack_n;
	logic [7:0] wdata = 8'h00, rdata, dout, ddev, pin;
	logic [4:0] ev = 0, en = 0, clr = 0, pend;
	sphp_cfg_t cfg = '0;
	int num_errors = 0, compares = 0;
	logic [7:0] exp_q[$];
	// the data wire: the port wins only while it drives
	assign pin = oe ? dout : ddev;
	sphp_port dut_u (.clk_sys_i(clk), .rst_i(rst), .cfg_i(cfg), .host_read_n_i(rd_n),
		.host_write_n_i(wr_n), .host_wdata_i(wdata), .host_rdata_o(rdata),
		.host_wready_o(wrdy), .input_strobe_n_i(stb_n), .ack_n_i(ack_n),
		.port_data_i(pin), .port_data_o(dout), .port_data_oe_o(oe),
		.input_buffer_full_o(input_buffer_full), .output_buffer_full_n_o(obf_n),
		.service_request_o(srq), .src_event_i(ev), .src_enable_i(en),
		.src_clear_i(clr), .src_pending_o(pend), .board_irq_o(irq));
	sphp_dev_model dev_u (.clk_sys_i(clk), .output_buffer_full_n_i(obf_n),
		.port_data_i(pin), .input_strobe_n_o(stb_n), .ack_n_o(ack_n), .data_o(ddev));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic t_irq;
		cfg = '{1'b1, 2'h1, 1'b1, 1'b0, 1'b0};
		clr = 5'h1f;
		cyc(1);
		clr = 5'h00;
		cfg.ie_out = 1'b1;
		cyc(3);
		check({7'h00, srq}, 8'h01);
		check({3'h0, pend}, 8'h08);
		cfg.ie_out = 1'b0;
		for (int i = 0; i < 5; i++) begin
			clr = 5'h1f;
			cyc(1);
			clr = 5'h00;
			ev = 5'h01 << i;
			cyc(1);
			ev = 5'h00;
			en = ~(5'h01 << i);
			cyc(2);
			check({3'h0, pend}, 8'h01 << i);
			check({7'h00, irq}, 8'h00);
			en = 5'h01 << i;
			cyc(2);
			check({7'h00, irq}, 8'h01);
		end
		clr = 5'h1f;
		ev = 5'h02;
		cyc(1);
		clr = 5'h00;
		ev = 5'h00;
		check({3'h0, pend}, 8'h02);
	endtask
	// a second strobe while full must not overwrite the latch
	task automatic t_in(input logic [1:0] m);
		logic [7:0] b = 8'ha4 + 8'(m);
		cfg = '{1'b1, m, 1'b0, 1'b1, 1'b0};
		cyc(2);
		dev_u.send(b);
		cyc(2);
		check({7'h00, input_buffer_full}, 8'h01);
		check({7'h00, srq}, 8'h01);
		dev_u.send(8'h3c);
		rd_n = 0;
		cyc(2);
		check(rdata, b);
		check({7'h00, input_buffer_full}, 8'h00);
		rd_n = 1;
		cyc(2);
	endtask
	task automatic t_out(input logic [1:0] m, input int w);
		cfg = '{1'b1, m, 1'b1, 1'b0, 1'b0};
		dev_u.ack_wait = w;
		dev_u.rx_q = {};
		exp_q = {};
		cyc(3);
		for (int i = 0; i < 12; i++) begin
			if (wrdy === 1'b1) exp_q.push_back(8'h10 + 8'(i));
			wdata = 8'h10 + 8'(i);
			wr_n = 0;
			cyc(1);
			wr_n = 1;
			cyc(2);
		end
		for (int k = 0; k < 900 && dev_u.rx_q.size() < exp_q.size(); k++) cyc(1);
		cyc(12);
		check(8'(dev_u.rx_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) check(dev_u.rx_q[i], exp_q[i]);
		check({7'h00, obf_n}, 8'h01);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		cyc(2);
		t_irq();
		t_in(2'h1);
		t_in(2'h2);
		t_out(2'h1, 40);
		check(8'(exp_q.size()), 8'h09);
		t_out(2'h2, 1);
		stop_test();
	end
	// watchdog: the full run needs well under 3000 cycles
	initial begin
		#20000;
		num_errors++;
		stop_test();
	end
endmodule
